//--- core/host_port_master.sv
// host-side controller driving the multiplexed halfword port pins
`timescale 1ns/10ps
`include "host_port_map.svh"
module host_port_master #(
  parameter int SETUP_CYC = `HP_SETUP_CYC,
  parameter int HOLD_CYC = `HP_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic reqValid,
  output logic reqReady,
  input wire host_port_pkg::access_t reqAccess,
  input wire logic reqRead,
  input wire logic reqSingle,
  input wire logic reqMsbFirst,
  input wire logic [31:0] reqWdata,
  output logic rspValid,
  input wire logic rspReady,
  output logic [31:0] rspRdata,
  output logic [1:0] access_select,
  output logic direction_select,
  output logic halfword_position,
  output logic port_selectN,
  output logic data_strobe_aN,
  output logic data_strobe_bN,
  output logic [15:0] hdOut,
  output logic hdOeN,
  input wire logic [15:0] hdIn,
  input wire logic wait_indicator
);
  import host_port_pkg::*;
  initial
  begin
    if (SETUP_CYC < 1 || SETUP_CYC > 15) $error("setup count out of range");
    if (HOLD_CYC < 1 || HOLD_CYC > 15) $error("hold count out of range");
  end
  // ==========================================
  // helpers
  // order bit decides which halfword of the word goes on the pins first
  function automatic logic [15:0] pickHalf(input logic [31:0] w, input logic msbFirst,
                                           input logic second);
    pickHalf = (msbFirst ^ second) ? w[31:16] : w[15:0];
  endfunction : pickHalf
  function automatic logic isControl(input access_t a);
    isControl = (a == `HP_SEL_CONTROL);
  endfunction : isControl
  // ==========================================
  // request latch
  phase_e state_q;
  phase_e state_d;
  access_t access_q;
  logic read_q;
  logic single_q;
  logic msbFirst_q;
  logic [31:0] wdata_q;
  logic second_q;
  logic [31:0] rdata_q;
  logic pushValid;
  logic pushReady;
  logic timerLoad;
  logic [`HP_CNT_W-1:0] timerValue;
  logic timerDone;
  logic lastHalf;
  assign reqReady = (state_q == ST_IDLE);
  assign lastHalf = second_q || (single_q && isControl(access_q));
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      access_q <= `HP_SEL_CONTROL;
      read_q <= `HP_DIR_READ;
      single_q <= 1'b0;
      msbFirst_q <= 1'b0;
      wdata_q <= '0;
    end
    else if (reqValid && reqReady)
    begin
      access_q <= reqAccess;
      read_q <= reqRead;
      single_q <= reqSingle && isControl(reqAccess);
      msbFirst_q <= reqMsbFirst;
      wdata_q <= reqWdata;
    end
  end
  // ==========================================
  // sequencer
  always_comb
  begin
    state_d = state_q;
    timerLoad = 1'b0;
    timerValue = '0;
    pushValid = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (reqValid)
        begin
          state_d = ST_SETUP;
          timerLoad = 1'b1;
          timerValue = `HP_CNT_W'(SETUP_CYC);
        end
      end
      ST_SETUP:
        if (timerDone) state_d = ST_STROBE;
      ST_STROBE:
        state_d = ST_WAITRDY;
      ST_WAITRDY:
      begin
        // the ready level is only trusted a cycle after the strobe fell
        if (!wait_indicator)
        begin
          state_d = ST_RELEASE;
          timerLoad = 1'b1;
          timerValue = `HP_CNT_W'(HOLD_CYC);
        end
      end
      ST_RELEASE:
      begin
        if (timerDone)
        begin
          if (lastHalf) state_d = ST_DONE;
          else
          begin
            state_d = ST_SETUP;
            timerLoad = 1'b1;
            timerValue = `HP_CNT_W'(SETUP_CYC);
          end
        end
      end
      ST_DONE:
      begin
        pushValid = 1'b1;
        if (pushReady) state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn) state_q <= ST_IDLE;
    else state_q <= state_d;
  end
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn) second_q <= 1'b0;
    else if (state_q == ST_IDLE) second_q <= 1'b0;
    else if (state_q == ST_RELEASE && timerDone && !lastHalf) second_q <= 1'b1;
  end
  // ==========================================
  // read data capture, before the strobe rises
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn) rdata_q <= '0;
    else if (state_q == ST_WAITRDY && !wait_indicator && read_q)
    begin
      if (isControl(access_q))
        rdata_q <= {hdIn, hdIn};
      else if (msbFirst_q ^ second_q)
        rdata_q[31:16] <= hdIn;
      else
        rdata_q[15:0] <= hdIn;
    end
  end
  // ==========================================
  // pins
  logic strobe_q;
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      access_select <= `HP_SEL_CONTROL;
      direction_select <= `HP_DIR_READ;
      halfword_position <= 1'b0;
      port_selectN <= 1'b1;
      strobe_q <= 1'b0;
      hdOut <= '0;
      hdOeN <= 1'b1;
    end
    else
    begin
      access_select <= access_q;
      direction_select <= read_q;
      halfword_position <= isControl(access_q) ? 1'b0 : second_q;
      // select held across both halves so the device never sees a strobe while deselected
      port_selectN <= (state_d == ST_IDLE) || (state_d == ST_DONE);
      strobe_q <= (state_d == ST_STROBE) || (state_d == ST_WAITRDY);
      hdOut <= pickHalf(wdata_q, msbFirst_q, second_q);
      hdOeN <= read_q || (state_d == ST_IDLE) || (state_d == ST_DONE);
    end
  end
  // one active-low strobe used, the other tied inactive; wait indicator drops on deselect anyway
  assign data_strobe_aN = ~strobe_q;
  assign data_strobe_bN = 1'b1;
  // ==========================================
  // parts
  strobe_timer #(
    .CNT_W(`HP_CNT_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .load(timerLoad),
    .loadValue(timerValue),
    .expired(timerDone)
  );
  // address increment per data access is the device's business
  word_skid #(
    .WIDTH(32)
  ) u_skid (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(read_q ? rdata_q : wdata_q),
    .outValid(rspValid),
    .outReady(rspReady),
    .outData(rspRdata)
  );
endmodule : host_port_master

//--- common/host_port_map.svh
// constants for the host-side halfword port controller
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH
`define HP_SEL_CONTROL 2'h0
`define HP_SEL_DATA_INC 2'h1
`define HP_SEL_ADDRESS 2'h2
`define HP_SEL_DATA_FIX 2'h3
`define HP_DIR_READ 1'h1
`define HP_DIR_WRITE 1'h0
`define HP_ORDER_BIT 0
`define HP_ORDER_MIRROR_BIT 8
`define HP_SETUP_NS 20
`define HP_SETUP_CYC ((`HP_SETUP_NS + 9) / 10)
`define HP_HOLD_NS 20
`define HP_HOLD_CYC ((`HP_HOLD_NS + 9) / 10)
`define HP_CNT_W 4
`endif

//--- common/host_port_pkg.sv
// types shared by the host-side halfword port controller
package host_port_pkg;
  typedef logic [1:0] access_t;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_WAITRDY = 3'b011,
    ST_RELEASE = 3'b100,
    ST_DONE = 3'b101
  } phase_e;
endpackage : host_port_pkg

//--- core/word_skid.sv
// two-entry buffer between the word source and its consumer
`timescale 1ns/10ps
module word_skid #(
  parameter int WIDTH = 32
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  // ==========================================
  // storage
  logic [WIDTH-1:0] mem_q [2];
  logic wrPtr_q;
  logic rdPtr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;
  initial
  begin
    if (WIDTH < 1) $error("word_skid width too small");
  end
  assign inReady = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end
    else if (push)
    begin
      mem_q[wrPtr_q] <= inData;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end
    else
    begin
      if (push) wrPtr_q <= ~wrPtr_q;
      if (pop) rdPtr_q <= ~rdPtr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : word_skid

//--- core/strobe_timer.sv
// phase counter that paces strobe setup and hold
`timescale 1ns/10ps
module strobe_timer #(
  parameter int CNT_W = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic load,
  input wire logic [CNT_W-1:0] loadValue,
  output logic expired
);
  logic [CNT_W-1:0] count_q;
  initial
  begin
    if (CNT_W < 2) $error("strobe_timer counter too narrow");
  end
  assign expired = (count_q == '0);
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn) count_q <= '0;
    else if (load) count_q <= loadValue;
    else if (count_q != '0) count_q <= count_q - 1'b1;
  end
endmodule : strobe_timer

//--- dv/host_port_props.sv
// pin-level assertions for the host-side port controller
`timescale 1ns/10ps
module host_port_props (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire host_port_pkg::access_t reqAccess,
  input wire logic reqRead,
  input wire logic [1:0] access_select,
  input wire logic direction_select,
  input wire logic halfword_position,
  input wire logic port_selectN,
  input wire logic data_strobe_aN,
  input wire logic hdOeN,
  input wire logic wait_indicator
);
  import host_port_pkg::*;
  access_t selQ;
  logic dirQ;
  logic strbQ;
  logic secondQ;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // =====
  // request copy: the request only stands at the take edge
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      selQ <= 2'h0;
      dirQ <= 1'b0;
      strbQ <= 1'b1;
      secondQ <= 1'b0;
    end
    else
    begin
      strbQ <= data_strobe_aN;
      if (reqValid && reqReady)
      begin
        selQ <= reqAccess;
        dirQ <= reqRead;
      end
      if (strbQ && !data_strobe_aN)
        secondQ <= ~secondQ;
    end
  // =====
  sel_gate_a: assert property (!data_strobe_aN |-> !port_selectN)
    else $error("strobe unselected");
  cycle_type_a: assert property (!data_strobe_aN |-> access_select == selQ
    && direction_select == dirQ) else $error("cycle type");
  rise_ready_a: assert property ($rose(data_strobe_aN) |-> !$past(wait_indicator))
    else $error("rise in wait");
  half_order_a: assert property (strbQ && !data_strobe_aN && selQ != 2'h0
    |-> halfword_position == secondQ) else $error("position");
  ctrl_pos_a: assert property (!data_strobe_aN && access_select == 2'h0
    |-> !halfword_position) else $error("ctrl position");
  read_free_a: assert property (!port_selectN && direction_select |-> hdOeN)
    else $error("read drive");
  write_drive_a: assert property (!data_strobe_aN && !direction_select |-> !hdOeN)
    else $error("write float");
  pair_whole_a: assert property (reqValid && reqReady |-> !secondQ && port_selectN)
    else $error("odd halves");
endmodule : host_port_props
bind host_port_master host_port_props u_props (.*);

//--- dv/host_port_device.sv
// behavioural device on the far side of the halfword port
`timescale 1ns/10ps
module host_port_device (
  input wire logic clk_sys,
  input wire logic [1:0] access_select,
  input wire logic direction_select,
  input wire logic halfword_position,
  input wire logic port_selectN,
  input wire logic data_strobe_aN,
  input wire logic data_strobe_bN,
  input wire logic [15:0] hdOut,
  input wire logic [2:0] slow,
  output logic [15:0] hdIn,
  output logic wait_indicator
);
  logic [31:0] mem [16];
  logic [31:0] addr = 32'h0;
  logic [31:0] tmp = 32'h0;
  logic [15:0] last = 16'h0;
  logic [1:0] sel = 2'h0;
  logic dir = 1'b0;
  logic pos = 1'b0;
  logic ord = 1'b0;
  logic [2:0] cnt = 3'h0;
  wire stb = port_selectN | ~(data_strobe_aN ^ data_strobe_bN);
  wire [31:0] word = (sel == 2'h2) ? addr : mem[addr[3:0]];
  wire [15:0] half = (pos == ord) ? word[15:0] : word[31:16];
  wire [15:0] ctl = {7'h0, ord, 7'h0, ord};
  // inverse of the last data while waiting or released, so a late sample is caught
  assign hdIn = (!stb && dir && cnt == 3'h0) ? ((sel == 2'h0) ? ctl : half) : ~last;
  assign wait_indicator = !port_selectN && cnt != 3'h0;
  always @(negedge stb)
  begin
    sel = access_select;
    dir = direction_select;
    pos = halfword_position;
    cnt = (sel == 2'h0) ? 3'h0 : slow;
  end
  // wait count steps after the edge so the controller samples a settled level
  always @(posedge clk_sys)
    if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  always @(posedge stb)
  begin
    last = (sel == 2'h0) ? ctl : half;
    if (sel == 2'h0 && !dir)
      ord = hdOut[0];
    if (sel != 2'h0 && !dir && pos == ord)
      tmp[15:0] = hdOut;
    if (sel != 2'h0 && !dir && pos != ord)
      tmp[31:16] = hdOut;
    if (sel == 2'h2 && !dir && pos)
      addr = tmp;
    if (sel[0] && !dir && pos)
      mem[addr[3:0]] = tmp;
    if (sel == 2'h1 && pos)
      addr = addr + 32'h1;
  end
endmodule : host_port_device

//--- dv/tb.sv
// self-checking bench for the host-side port controller
`timescale 1ns/10ps
module tb;
  import host_port_pkg::*;
  logic clk_sys = 0, resetn = 0, reqValid = 0, reqRead = 0, reqSingle = 0;
  logic reqMsbFirst = 0, rspReady = 0, reqReady, rspValid, direction_select;
  logic halfword_position, port_selectN, data_strobe_aN, data_strobe_bN;
  logic hdOeN, wait_indicator;
  access_t reqAccess = 2'h0;
  logic [1:0] access_select;
  logic [31:0] reqWdata = 32'h0, rspRdata;
  logic [15:0] hdOut, hdIn, lfsr = 16'h8245;
  logic [2:0] slow = 3'h0;
  logic [31:0] expQ[$];
  int failures = 0, checks = 0, cycles = 0;
  always #5 clk_sys = ~clk_sys;
  host_port_master dut_u (.*);
  host_port_device dev_u (.*);
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  // =====
  // one access; writes answer with their own data echoed
  task automatic acc(input access_t a, input logic rd, input logic [31:0] w);
    @(negedge clk_sys);
    while (reqReady !== 1'b1)
      @(negedge clk_sys);
    slow = lfsr[4:2];
    reqAccess = a;
    reqRead = rd;
    reqWdata = w;
    reqValid = 1'b1;
    @(negedge clk_sys);
    reqValid = 1'b0;
  endtask : acc
  // receiver stalls at random, never long enough for the buffer to fill
  always @(negedge clk_sys)
  begin
    lfsr = nxt(lfsr);
    rspReady = lfsr[0] | lfsr[1];
  end
  always @(posedge clk_sys)
    if (rspValid === 1'b1 && rspReady === 1'b1)
      check(rspRdata, expQ.pop_front());
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      stop_test();
    end
  end
  // =====
  initial
  begin
    logic [31:0] a, w0, w1, hw;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys) resetn = 1'b1;
    for (int o = 1; o >= 0; o--)
    begin
      reqMsbFirst = o[0];
      a = {28'h0, lfsr[3:0]};
      w0 = {lfsr, nxt(lfsr)};
      w1 = {nxt(lfsr), ~lfsr};
      hw = {2{7'h0, o[0], 7'h0, o[0]}};
      expQ = {expQ, hw, hw, a, a, w0, w1, a, w0, w0, w1};
      acc(2'h0, 1'b0, hw);
      acc(2'h0, 1'b1, 32'h0);
      acc(2'h2, 1'b0, a);
      acc(2'h2, 1'b1, 32'h0);
      acc(2'h1, 1'b0, w0);
      acc(2'h1, 1'b0, w1);
      acc(2'h2, 1'b0, a);
      acc(2'h3, 1'b1, 32'h0);
      acc(2'h1, 1'b1, 32'h0);
      acc(2'h1, 1'b1, 32'h0);
      $display("order %0d test done", o);
    end
    while (expQ.size() != 0)
      @(posedge clk_sys);
    stop_test();
  end
endmodule : tb
